// file: src/mpwm_map.svh
`ifndef MPWM_MAP_SVH
`define MPWM_MAP_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define CNT_W      16
`define CH_W       8
`define ADDR_W     8
`define DATA_W     32

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_PERIOD 8'h00
`define OFF_DUTY1  8'h04
`define OFF_DUTY2  8'h08
`define OFF_MCNT   8'h0C
`define OFF_S1CNT  8'h10
`define OFF_S2CNT  8'h14
`define OFF_START  8'h18
`define OFF_STOP   8'h1C
`define OFF_ENSTAT 8'h20
`define OFF_TOE    8'h24
`define OFF_TOV    8'h28
`define OFF_TOL    8'h2C
`define OFF_TOM    8'h30
`define OFF_PER    8'h34

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PER_POWER_BIT 0
`define RST_DATA      16'h0000
`define RST_BITS      8'h00
`define ZERO_WORD     32'h0000_0000
`define CNT_ONE       16'h0001

`endif

// file: src/mpwm_pkg.sv
package mpwm_pkg;
  `include "mpwm_map.svh"

  typedef enum logic {
    CH_STOP = 1'b0,
    CH_RUN  = 1'b1
  } chan_run_t;

  typedef struct packed {
    logic                               power;
    logic [`CNT_W-1:0]                  period;
    logic [1:0][`CNT_W-1:0]             duty;
    logic [`CNT_W-1:0]                  mcnt;
    chan_run_t                          run;
    logic                               irq;
    logic [`CH_W-1:0]                   toe;
    logic [`CH_W-1:0]                   tov;
    logic [`CH_W-1:0]                   tol;
    logic [`CH_W-1:0]                   tom;
    logic [`DATA_W-1:0]                 rdata;
    logic                               err;
  } main_state_t;

  typedef struct packed {
    logic [`CNT_W-1:0]                  cnt;
    logic                               run;
    logic                               active;
  } slave_state_t;
endpackage

// file: src/mpwm_if.sv
`timescale 1ns/1ns
interface mpwm_if;
  logic        en;
  logic        reload;
  logic        clr;
  logic [15:0] duty;
  logic [15:0] cnt;
  logic        active;
  logic        active_next;
  logic        change;

  modport ctrl (output en, reload, clr, duty, input cnt, active, active_next, change);
  modport chan (input en, reload, clr, duty, output cnt, active, active_next, change);
endinterface

// file: src/slave_channel.sv
`timescale 1ns/1ns
module slave_channel (
  input wire logic core_clk, // count clock
  input wire logic nrst,     // sync reset, active low
  mpwm_if.chan     port      // link to the master logic
);
  import mpwm_pkg::*;

  slave_state_t s;
  slave_state_t next_s;

  // ----------------------------------------
  // duty counter
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (port.clr) begin
      next_s = '0;
    end else if (port.en) begin
      if (port.reload) begin
        // a zero duty never goes active, giving a 0 % pulse
        next_s.cnt    = port.duty;
        next_s.run    = (port.duty != `RST_DATA);
        next_s.active = (port.duty != `RST_DATA);
      end else if (s.run) begin
        next_s.cnt = s.cnt - `CNT_ONE;
        if (s.cnt == `CNT_ONE) begin
          next_s.run    = 1'b0;
          next_s.active = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.cnt         = s.cnt;
  assign port.active      = s.active;
  assign port.active_next = next_s.active;
  assign port.change      = (next_s.active != s.active);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  load_on_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
    port.en && port.reload && !port.clr |=> s.cnt == $past(port.duty))
    else $error("slave did not load duty on period event");

  active_after_a: assert property (@(posedge core_clk) disable iff (!nrst)
    port.en && port.reload && !port.clr && port.duty != `RST_DATA |=> s.active && s.run)
    else $error("slave not active one clock after period event");

  stop_at_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    port.en && !port.reload && !port.clr && s.run && s.cnt == `CNT_ONE
    |=> s.cnt == `RST_DATA && !s.active && !s.run)
    else $error("slave did not go inactive and stop at zero");

  hold_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !port.en && !port.clr |=> $stable(s.cnt) && $stable(s.active))
    else $error("slave moved while disabled");
endmodule

// file: src/multi_pwm.sv
`timescale 1ns/1ns
module multi_pwm #(
  parameter int unsigned MASTER_IDX = 0                   // master channel: 0, 2 or 4
) (
  input  wire logic                   core_clk,          // count clock, 100 MHz
  input  wire logic                   nrst,              // sync reset, active low
  input  wire logic                   psel,              // apb select
  input  wire logic                   penable,           // apb enable
  input  wire logic                   pwrite,            // apb direction
  input  wire logic [`ADDR_W-1:0]     paddr,             // apb byte address
  input  wire logic [`DATA_W-1:0]     pwdata,            // apb write data
  output logic      [`DATA_W-1:0]     prdata,            // apb read data
  output logic                        pready,            // apb ready
  output logic                        pslverr,           // apb error
  output logic                        master_period_irq, // period event pulse
  output logic                        slave1_output,     // first pwm pin
  output logic                        slave2_output,     // second pwm pin
  output logic                        timer_pin_sel      // 1 timer function, 0 port mode
);
  import mpwm_pkg::*;

  localparam int unsigned M_BIT = MASTER_IDX;
  localparam int unsigned P_BIT = MASTER_IDX + 1;
  localparam int unsigned Q_BIT = MASTER_IDX + 2;

  main_state_t s;
  main_state_t next_s;

  logic [1:0][`CNT_W-1:0] s_cnt;
  logic [1:0]             s_active;
  logic [1:0]             s_active_next;
  logic [1:0]             s_change;

  logic                   setup;
  logic                   wr;
  logic                   start_wr;
  logic                   stop_wr;
  logic                   per_wr;
  logic                   tov_wr;
  logic                   toe_wr;
  logic                   ctl_wr;
  logic [1:0]             wr_bits;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // trigger bits act only when all three channels are named together
  function automatic logic group_trig(input logic [`DATA_W-1:0] d);
    group_trig = d[M_BIT] & d[P_BIT] & d[Q_BIT];
  endfunction

  function automatic logic [`CH_W-1:0] group_mask();
    logic [`CH_W-1:0] m;
    m        = `RST_BITS;
    m[M_BIT] = 1'b1;
    m[P_BIT] = 1'b1;
    m[Q_BIT] = 1'b1;
    group_mask = m;
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // zero wait states: every access phase completes at once
  assign pready  = 1'b1;
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign prdata  = s.rdata;
  assign pslverr = s.err & psel & penable;

  // while powered off only the power bit accepts a write
  assign per_wr   = wr && (paddr == `OFF_PER);
  assign start_wr = wr && s.power && (paddr == `OFF_START) && group_trig(pwdata);
  assign stop_wr  = wr && s.power && (paddr == `OFF_STOP) && group_trig(pwdata);
  assign tov_wr   = wr && s.power && (paddr == `OFF_TOV);
  assign toe_wr   = wr && s.power && (paddr == `OFF_TOE);
  assign ctl_wr   = start_wr | stop_wr | per_wr;
  assign wr_bits  = {pwdata[Q_BIT], pwdata[P_BIT]};

  // ----------------------------------------
  // slave channels
  // ----------------------------------------
  mpwm_if sif [2] ();

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_slave
      slave_channel u_chan (
        .core_clk (core_clk),
        .nrst     (nrst),
        .port     (sif[g])
      );
      assign sif[g].en        = (s.run == CH_RUN);
      assign sif[g].reload    = s.irq;
      assign sif[g].clr       = ~s.power;
      assign sif[g].duty      = s.duty[g];
      assign s_cnt[g]         = sif[g].cnt;
      assign s_active[g]      = sif[g].active;
      assign s_active_next[g] = sif[g].active_next;
      assign s_change[g]      = sif[g].change;
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s     = s;
    next_s.irq = 1'b0;

    // master counter
    unique case (s.run)
      CH_STOP: begin
        next_s.mcnt = s.mcnt;
      end
      CH_RUN: begin
        if (s.mcnt == `RST_DATA) begin
          // period register is sampled here, so rewrites take effect next period
          next_s.mcnt = s.period;
          next_s.irq  = 1'b1;
        end else begin
          next_s.mcnt = s.mcnt - `CNT_ONE;
        end
      end
    endcase

    // slave output latches follow the counter only in combination mode
    for (int i = 0; i < 2; i++) begin
      if (s_change[i] && s.toe[P_BIT + i] && s.tom[P_BIT + i]) begin
        next_s.tov[P_BIT + i] = s_active_next[i] ^ s.tol[P_BIT + i];
      end
    end

    // register writes
    if (wr && s.power) begin
      unique case (paddr)
        `OFF_PERIOD: next_s.period  = pwdata[`CNT_W-1:0];
        `OFF_DUTY1:  next_s.duty[0] = pwdata[`CNT_W-1:0];
        `OFF_DUTY2:  next_s.duty[1] = pwdata[`CNT_W-1:0];
        `OFF_TOE:    next_s.toe     = pwdata[`CH_W-1:0];
        // bits under counter control keep the hardware value
        `OFF_TOV:    next_s.tov     = (next_s.tov & s.toe) | (pwdata[`CH_W-1:0] & ~s.toe);
        `OFF_TOL:    next_s.tol     = pwdata[`CH_W-1:0];
        `OFF_TOM:    next_s.tom     = pwdata[`CH_W-1:0];
        default: begin
        end
      endcase
    end

    if (start_wr) begin
      next_s.run  = CH_RUN;
      next_s.mcnt = s.period;
      next_s.irq  = 1'b1;
    end

    if (stop_wr) begin
      // counters and output latches are not cleared: they still take this cycle's step, then hold
      next_s.run = CH_STOP;
      next_s.irq = 1'b0;
    end

    // read data is captured in the setup cycle, one clock before the access edge
    if (setup) begin
      next_s.err = 1'b0;
      unique case (paddr)
        `OFF_PERIOD: next_s.rdata = {16'h0000, s.period};
        `OFF_DUTY1:  next_s.rdata = {16'h0000, s.duty[0]};
        `OFF_DUTY2:  next_s.rdata = {16'h0000, s.duty[1]};
        `OFF_MCNT:   next_s.rdata = {16'h0000, s.mcnt};
        `OFF_S1CNT:  next_s.rdata = {16'h0000, s_cnt[0]};
        `OFF_S2CNT:  next_s.rdata = {16'h0000, s_cnt[1]};
        `OFF_START:  next_s.rdata = `ZERO_WORD;
        `OFF_STOP:   next_s.rdata = `ZERO_WORD;
        `OFF_ENSTAT: next_s.rdata = {24'h00_0000, (s.run == CH_RUN) ? group_mask() : `RST_BITS};
        `OFF_TOE:    next_s.rdata = {24'h00_0000, s.toe};
        `OFF_TOV:    next_s.rdata = {24'h00_0000, s.tov};
        `OFF_TOL:    next_s.rdata = {24'h00_0000, s.tol};
        `OFF_TOM:    next_s.rdata = {24'h00_0000, s.tom};
        `OFF_PER:    next_s.rdata = {31'h0000_0000, s.power};
        default: begin
          next_s.rdata = `ZERO_WORD;
          next_s.err   = 1'b1;
        end
      endcase
    end

    // power enable: clearing it puts the unit back to its reset state, all but the read data and error flag
    if (per_wr) begin
      next_s.power = pwdata[`PER_POWER_BIT];
      if (!pwdata[`PER_POWER_BIT]) begin
        next_s       = '0;
        next_s.rdata = s.rdata;
        next_s.err   = s.err;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign master_period_irq = s.irq;
  assign slave1_output     = s.tov[P_BIT];
  assign slave2_output     = s.tov[Q_BIT];
  assign timer_pin_sel     = s.power;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  irq_on_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
    start_wr |=> master_period_irq && s.mcnt == $past(s.period))
    else $error("no period event when master starts");

  enable_status_a: assert property (@(posedge core_clk) disable iff (!nrst)
    start_wr |=> s.run == CH_RUN ##1 setup && paddr == `OFF_ENSTAT && !ctl_wr
    |=> prdata[M_BIT] && prdata[P_BIT] && prdata[Q_BIT])
    else $error("enable status not set after start");

  reload_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    s.run == CH_RUN && s.mcnt == `RST_DATA && !ctl_wr
    |=> master_period_irq && s.mcnt == $past(s.period))
    else $error("master did not reload at zero");

  count_down_a: assert property (@(posedge core_clk) disable iff (!nrst)
    s.run == CH_RUN && s.mcnt != `RST_DATA && !ctl_wr
    |=> !master_period_irq && s.mcnt == $past(s.mcnt) - `CNT_ONE)
    else $error("master did not count down by one");

  count_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    setup && paddr == `OFF_MCNT |=> prdata[`CNT_W-1:0] == $past(s.mcnt))
    else $error("master counter read back wrong");

  stop_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    stop_wr |=> s.run == CH_STOP ##1 (ctl_wr || $stable(s.mcnt)))
    else $error("stop did not halt master");

  out_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    s.run == CH_STOP && !tov_wr && !per_wr |=> $stable(slave1_output) && $stable(slave2_output))
    else $error("slave output moved while stopped");

  soft_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tov_wr && !s.toe[P_BIT] |=> slave1_output == $past(wr_bits[0]))
    else $error("written output level not driven");

  level_sense_a: assert property (@(posedge core_clk) disable iff (!nrst)
    s_change[0] && s.toe[P_BIT] && s.tom[P_BIT] && !tov_wr && !per_wr
    |=> slave1_output == ($past(s_active_next[0]) ^ $past(s.tol[P_BIT])))
    else $error("slave output level sense wrong");

  enable_wr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    toe_wr && s.run == CH_RUN |=> s.toe == $past(pwdata[`CH_W-1:0]))
    else $error("output enable write refused while running");

  power_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
    per_wr && !pwdata[`PER_POWER_BIT]
    |=> s.tov == `RST_BITS && !timer_pin_sel && s.run == CH_STOP && s.mcnt == `RST_DATA)
    else $error("power off did not reset the unit");
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
`include "mpwm_map.svh"
module tb;
  import mpwm_pkg::*;
  // ----------------------------------------
  // signals and stimulus tables
  // ----------------------------------------
  localparam int unsigned MASTER = 2;            // non-default slot, slaves on bits 3 and 4
  localparam logic [31:0] TRIG   = 32'h0000_001C; // master and both slaves together
  typedef struct packed {
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [7:0]  raddr;
    logic [31:0] exp;
  } reg_row_t;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        pin1;
  logic        pin2;
  logic        pin_sel;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches  = 0;
  int          check_count = 0;
  // config rows also serve as setup for the first run: period 3, duty 2 and 1
  reg_row_t regs [10] = '{
    '{`OFF_PERIOD, 32'h0000_0003, `OFF_PERIOD, 32'h0000_0003},
    '{`OFF_DUTY1,  32'hFFFF_0002, `OFF_DUTY1,  32'h0000_0002},
    '{`OFF_DUTY2,  32'h0000_0001, `OFF_DUTY2,  32'h0000_0001},
    '{`OFF_TOE,    32'h0000_0118, `OFF_TOE,    32'h0000_0018},
    '{`OFF_TOM,    32'h0000_0018, `OFF_TOM,    32'h0000_0018},
    '{`OFF_TOL,    32'h0000_0000, `OFF_TOL,    32'h0000_0000},
    '{`OFF_TOV,    32'h0000_0000, `OFF_TOV,    32'h0000_0000},
    '{`OFF_START,  32'h0000_000C, `OFF_ENSTAT, 32'h0000_0000},
    '{`OFF_MCNT,   32'h0000_0055, `OFF_MCNT,   32'h0000_0000},
    '{`OFF_STOP,   32'h0000_001C, `OFF_STOP,   32'h0000_0000}
  };
  // per cycle after start: period event, first pin, second pin
  logic [2:0]  walk [8] = '{3'h4, 3'h3, 3'h2, 3'h0, 3'h4, 3'h3, 3'h2, 3'h0};

  multi_pwm #(.MASTER_IDX(MASTER)) multi_pwm_i (
    .core_clk          (core_clk),
    .nrst              (nrst),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .master_period_irq (irq),
    .slave1_output     (pin1),
    .slave2_output     (pin2),
    .timer_pin_sel     (pin_sel)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  // entered right after an edge; leaves the request up so a second transfer can follow at once
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] %0t bus wait limit reached", $time);
    end
    rdat = prdata;
    rerr = pslverr;
  endtask
  task automatic apb_end();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb_xfer(1'b1, addr, data);
    apb_end();
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] addr);
    apb_xfer(1'b0, addr, 32'h0000_0000);
    apb_end();
    @(posedge core_clk);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      mismatches++;
      $display("[ERR] %0t count %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  // samples 1 ns after the edge, then realigns to an edge for the next bus call
  task automatic chk_pins(input logic p1, input logic p2, input logic sel);
    #1;
    chk_bit(pin1, p1);
    chk_bit(pin2, p2);
    chk_bit(pin_sel, sel);
    @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk_pins(1'b0, 1'b0, 1'b0);
    wr(`OFF_PER, 32'h0000_0001);
    chk_pins(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 10; i++) begin
      wr(regs[i].waddr, regs[i].wdata);
      rd(regs[i].raddr);
      chk_word(rdat, regs[i].exp);
    end
    apb_xfer(1'b1, `OFF_START, TRIG);
    apb_end();
    for (int i = 0; i < 8; i++) begin
      #1;
      chk_bit(irq, walk[i][2]);
      chk_bit(pin1, walk[i][1]);
      chk_bit(pin2, walk[i][0]);
      @(posedge core_clk);
    end
    rd(`OFF_ENSTAT);
    chk_word(rdat, TRIG);
    rd(`OFF_MCNT);
    chk_in(rdat, 32'h0000_0000, 32'h0000_0003);
    wr(`OFF_TOE, 32'h0000_0018);
    rd(`OFF_TOE);
    chk_word(rdat, 32'h0000_0018);
    wr(`OFF_STOP, TRIG);
    rd(`OFF_ENSTAT);
    chk_word(rdat, 32'h0000_0000);
    wr(`OFF_TOE, 32'h0000_0000);
    wr(`OFF_TOV, 32'h0000_0008);
    @(posedge core_clk);
    chk_pins(1'b1, 1'b0, 1'b1);
    // second run: inverted second slave, stop issued back to back with start
    wr(`OFF_TOV, 32'h0000_0018);
    wr(`OFF_TOL, 32'h0000_0010);
    wr(`OFF_PERIOD, 32'h0000_0007);
    wr(`OFF_DUTY1, 32'h0000_0005);
    wr(`OFF_DUTY2, 32'h0000_0003);
    wr(`OFF_TOE, 32'h0000_0018);
    apb_xfer(1'b1, `OFF_START, TRIG);
    apb_xfer(1'b1, `OFF_STOP, TRIG);
    apb_end();
    repeat (20) begin
      @(posedge core_clk);
      #1;
      chk_bit(irq, 1'b0);
    end
    chk_pins(1'b1, 1'b0, 1'b1);
    rd(`OFF_MCNT);
    chk_in(rdat, 32'h0000_0005, 32'h0000_0006);
    rd(`OFF_S1CNT);
    chk_in(rdat, 32'h0000_0004, 32'h0000_0005);
    rd(`OFF_S2CNT);
    chk_in(rdat, 32'h0000_0002, 32'h0000_0003);
    rd(`OFF_ENSTAT);
    chk_word(rdat, 32'h0000_0000);
    wr(`OFF_PER, 32'h0000_0000);
    @(posedge core_clk);
    chk_pins(1'b0, 1'b0, 1'b0);
    wr(`OFF_PER, 32'h0000_0001);
    for (int a = 0; a <= 'h30; a += 4) begin
      rd(8'(a));
      chk_word(rdat, 32'h0000_0000);
    end
    rd(8'h3C);
    chk_bit(rerr, 1'b1);
    chk_word(rdat, 32'h0000_0000);
    end_of_test();
  end
endmodule
